//--- hw/abs_xfer_dev.sv
// Drive end: serves the 80-bit absolute position frame one bit per handshake
`timescale 1ns/1ns
module abs_xfer_dev
   import abs_xfer_pkg::*;
#(
   parameter int unsigned ACK_TIMEOUT_CYC = ACK_TIMEOUT_CYC_DFLT // Ack timeout in cycles
)(
   input  wire logic        ref_clk_i,     // 20 MHz clock
   input  wire logic        reset_n_i,     // Asynchronous reset, low
   input  wire logic        ce_i,          // Clock enable, low freezes all state
   abs_xfer_if.dev          link,          // Pins toward the controller
   input  wire logic [15:0] status_word_i, // Position status word
   input  wire logic [15:0] revolutions_i, // Signed revolution count
   input  wire logic [31:0] pulses_i,      // Encoder pulse count
   input  wire logic        param_wr_i,    // Init parameter write strobe
   input  wire logic [15:0] param_data_i,  // Init parameter write value
   input  wire logic        dflt_ready_i,  // Default function of the ready pin
   input  wire logic        dflt_value_i,  // Default function of the value pin
   input  wire logic        dflt_error_i,  // Default function of the error pin
   output logic             req_dflt_o,    // Request pin in its default role
   output logic             zero_dflt_o,   // Zeroing pin in its default role
   output logic             coord_init_o,  // Pulse: clear the encoder pulse count
   output logic             frame_done_o   // All 80 bits delivered
);

   ////////////////////////////////////////////////////////////////////////////
   // Types and constants

   typedef enum logic [5:0]
   {
      D_IDLE  = 6'b000001, // Transfer mode off
      D_WAIT  = 6'b000010, // Waiting for request low
      D_PREP  = 6'b000100, // Counting the request-to-ready delay
      D_READY = 6'b001000, // Ready high, waiting for acknowledge
      D_REL   = 6'b010000, // Counting the release delay
      D_DONE  = 6'b100000  // Frame complete
   } dev_state_type;

   localparam logic [31:0] READY_LAST   = 32'(REQUEST_TO_READY_CYC - 1);
   localparam logic [31:0] REL_LAST     = 32'(ACK_TO_RELEASE_CYC - 1);
   localparam logic [31:0] TIMEOUT_LAST = 32'(ACK_TIMEOUT_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   dev_state_type          state_q;     // Handshake state
   dev_state_type          state_d;
   logic                   err_q;       // Timed out; held until enable drops
   logic                   err_d;
   logic [31:0]            tmr_q;       // Shared delay counter
   logic [31:0]            tmr_d;
   logic [IDX_W-1:0]       idx_q;       // Next frame bit to send
   logic [IDX_W-1:0]       idx_d;
   logic [FRAME_BITS-1:0]  frame_q;     // Frame captured at enable
   logic                   zero_prev_q; // Zeroing pin last cycle
   logic                   ready_pin_q; // Ready pin flop
   logic                   value_pin_q; // Value pin flop
   logic                   error_pin_q; // Error pin flop

   wire                    en;          // Transfer mode active
   wire                    req_low;     // Controller asks for a bit
   wire                    zero_rise;   // Zeroing edge seen while enabled
   wire                    param_hit;   // Init parameter written with one
   wire [31:0]             pulse_sat;   // Pulse count limited to its range
   wire [15:0]             c0;          // Checksum chain stages
   wire [15:0]             c1;
   wire [15:0]             c2;
   wire [15:0]             csum;        // Final checksum
   wire [FRAME_BITS-1:0]   frame_d;     // Frame as it would be captured
   wire                    bit_sel;     // Current frame bit
   wire                    ready_pin_d;
   wire                    value_pin_d;
   wire                    error_pin_d;

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   assign en        = link.xfer_enable;
   assign req_low   = ~link.bit_request_n;
   // Edge only counts in transfer mode; the pin has another role otherwise
   assign zero_rise = en & link.coord_zero & ~zero_prev_q;
   assign param_hit = param_wr_i & (param_data_i == COORD_INIT_VALUE);

   // Revolutions are already a 16-bit signed range; pulses are capped
   assign pulse_sat = (pulses_i > PULSE_MAX) ? PULSE_MAX : pulses_i;

   // Unsigned 16-bit arithmetic, carries dropped on purpose
   assign c0   = 16'(status_word_i + CSUM_ADD0) ^ revolutions_i;
   assign c1   = 16'(c0 + CSUM_ADD1) ^ pulse_sat[15:0];
   assign c2   = 16'(c1 + CSUM_ADD2) ^ pulse_sat[31:16];
   // Formula addend used; the alternative stays in the package for a swap
   assign csum = 16'(c2 + CSUM_FINAL);

   assign frame_d = {csum, pulse_sat, revolutions_i, status_word_i};

   // Ascending order from bit 0; past the end the line idles low
   assign bit_sel = (idx_q <= LAST_BIT) ? frame_q[idx_q] : 1'b0;

   // Pin functions follow the enable input
   assign ready_pin_d = en ? (state_d == D_READY || state_d == D_REL) : dflt_ready_i;
   assign value_pin_d = en ? bit_sel : dflt_value_i;
   assign error_pin_d = en ? err_d : dflt_error_i;

   ////////////////////////////////////////////////////////////////////////////
   // Handshake sequencing

   // Next state; enable low overrides everything below it
   always_comb
   begin
      state_d = state_q;
      err_d   = err_q;
      tmr_d   = tmr_q + 32'h1;
      idx_d   = idx_q;
      unique case (state_q)
         D_IDLE:
         begin
            tmr_d = '0;
            if (en)
               state_d = D_WAIT;
         end
         D_WAIT:
         begin
            tmr_d = '0;
            // Refuse new bits after a timeout until enable drops
            if (req_low && !err_q)
               state_d = D_PREP;
         end
         D_PREP:
         begin
            // Bit is already on the value pin; ready follows after the delay
            if (tmr_q == READY_LAST)
            begin
               state_d = D_READY;
               tmr_d   = '0;
            end
         end
         D_READY:
         begin
            if (!req_low)
            begin
               state_d = D_REL;
               tmr_d   = '0;
            end
            else if (tmr_q == TIMEOUT_LAST)
            begin
               // No acknowledge in time: stop and flag
               state_d = D_WAIT;
               err_d   = 1'b1;
            end
         end
         D_REL:
         begin
            if (tmr_q == REL_LAST)
            begin
               tmr_d   = '0;
               idx_d   = idx_q + 7'h1;
               state_d = (idx_q == LAST_BIT) ? D_DONE : D_WAIT;
            end
         end
         D_DONE:
         begin
            tmr_d = '0;
         end
      endcase
      if (!en)
      begin
         // Abort, rewind and clear the error
         state_d = D_IDLE;
         err_d   = 1'b0;
         idx_d   = FIRST_BIT;
         tmr_d   = '0;
      end
   end

   // State registers
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_q <= D_IDLE;
         err_q   <= 1'b0;
         tmr_q   <= '0;
         idx_q   <= FIRST_BIT;
      end
      else if (ce_i)
      begin
         state_q <= state_d;
         err_q   <= err_d;
         tmr_q   <= tmr_d;
         idx_q   <= idx_d;
      end
   end

   // Frame snapshot at the start of transfer mode so all 80 bits agree
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         frame_q <= '0;
      else if (ce_i && state_q == D_IDLE && en)
         frame_q <= frame_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin and side outputs, all registered

   // Ready only rises once the bit has stood for the whole prep delay
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ready_pin_q  <= 1'b0;
         value_pin_q  <= 1'b0;
         error_pin_q  <= 1'b0;
         zero_prev_q  <= 1'b0;
         req_dflt_o   <= 1'b1;
         zero_dflt_o  <= 1'b0;
         coord_init_o <= 1'b0;
         frame_done_o <= 1'b0;
      end
      else if (ce_i)
      begin
         ready_pin_q  <= ready_pin_d;
         value_pin_q  <= value_pin_d;
         error_pin_q  <= error_pin_d;
         zero_prev_q  <= link.coord_zero;
         // In transfer mode the default roles see idle levels
         req_dflt_o   <= en | link.bit_request_n;
         zero_dflt_o  <= ~en & link.coord_zero;
         coord_init_o <= zero_rise | param_hit;
         frame_done_o <= (state_d == D_DONE);
      end
   end

   assign link.bit_ready  = ready_pin_q;
   assign link.bit_value  = value_pin_q;
   assign link.xfer_error = error_pin_q;

endmodule

//--- hw/abs_xfer_host.sv
// Controller end with its receive word FIFO
`timescale 1ns/1ns
module abs_word_fifo #(
   parameter int WIDTH = 16, // Word width
   parameter int DEPTH = 8   // Words held
)(
   input  wire logic             ref_clk_i, // Clock
   input  wire logic             reset_n_i, // Asynchronous reset, low
   input  wire logic             ce_i,      // Clock enable
   input  wire logic             s_valid_i, // Write side valid
   output logic                  s_ready_o, // Not full
   input  wire logic [WIDTH-1:0] s_data_i,  // Write data
   output logic                  m_valid_o, // Not empty
   input  wire logic             m_ready_i, // Read side ready
   output logic [WIDTH-1:0]      m_data_o   // Oldest word
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];  // Storage
   logic [PW-1:0]    wr_q;         // Write pointer
   logic [PW-1:0]    rd_q;         // Read pointer
   logic [PW:0]      cnt_q;        // Words held
   wire              push;
   wire              pop;
   wire [PW:0]       cnt_d;

   assign push  = s_valid_i & s_ready_o;
   assign pop   = m_valid_o & m_ready_i;
   assign cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
   assign m_data_o = mem[rd_q];

   // Pointers wrap naturally since depth is a power of two
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wr_q      <= '0;
         rd_q      <= '0;
         cnt_q     <= '0;
         s_ready_o <= 1'b1;
         m_valid_o <= 1'b0;
      end
      else if (ce_i)
      begin
         wr_q      <= wr_q + PW'(push);
         rd_q      <= rd_q + PW'(pop);
         cnt_q     <= cnt_d;
         s_ready_o <= (cnt_d != FULL_CNT);
         m_valid_o <= (cnt_d != '0);
      end
   end

   // Storage has no reset; reads are gated by m_valid_o
   always_ff @(posedge ref_clk_i)
   begin
      if (ce_i && push)
         mem[wr_q] <= s_data_i;
   end
endmodule

////////////////////////////////////////////////////////////////////////////////

module abs_xfer_host
   import abs_xfer_pkg::*;
(
   input  wire logic        ref_clk_i,    // 20 MHz clock
   input  wire logic        reset_n_i,    // Asynchronous reset, low
   input  wire logic        ce_i,         // Clock enable
   abs_xfer_if.host         link,         // Pins toward the drive
   input  wire logic        run_i,        // Level: read one frame
   input  wire logic        zero_req_i,   // Pulse: zero coordinates at next start
   output logic             word_valid_o, // Received word available
   output logic [15:0]      word_data_o,  // Words 0..4, checksum last
   input  wire logic        word_ready_i, // Consumer takes the word
   output logic             error_o,      // Drive reported a timeout
   output logic             done_o        // Frame fully received
);

   typedef enum logic [7:0]
   {
      H_OFF    = 8'b00000001, // Enable low
      H_SETTLE = 8'b00000010, // Pins switching over
      H_ZERO   = 8'b00000100, // Holding the zeroing input
      H_REQ    = 8'b00001000, // Request low, waiting for ready
      H_ACK    = 8'b00010000, // Request high, waiting for ready low
      H_PUSH   = 8'b00100000, // Handing a word to the FIFO
      H_DONE   = 8'b01000000, // Frame received
      H_FAULT  = 8'b10000000  // Error seen, enable dropped
   } host_state_type;

   localparam logic [15:0] SETTLE_LAST = 16'(ENABLE_SETTLE_CYC - 1);
   localparam logic [15:0] ZERO_LAST   = 16'(ZERO_HOLD_CYC - 1);

   host_state_type   st_q;       // Sequencer state
   logic [15:0]      tmr_q;      // Settle and hold counter
   logic [IDX_W-1:0] cnt_q;      // Bits received
   logic [15:0]      sr_q;       // Word being assembled, LSB first
   logic             zpend_q;    // Zeroing requested
   logic             en_q;       // Enable pin flop
   logic             req_n_q;    // Request pin flop
   logic             zero_q;     // Zeroing pin flop
   wire              fifo_rdy;   // FIFO can take a word
   wire              push;       // Word offered to FIFO

   assign push = (st_q == H_PUSH);

   // A finished word waits in H_PUSH until there is room, so a slow consumer stalls
   // the bit requests instead of losing data
   abs_word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .ce_i      (ce_i),
      .s_valid_i (push),
      .s_ready_o (fifo_rdy),
      .s_data_i  (sr_q),
      .m_valid_o (word_valid_o),
      .m_ready_i (word_ready_i),
      .m_data_o  (word_data_o)
   );

   // Sequencer; pin levels are registered alongside the state
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st_q <= H_OFF; tmr_q <= '0; cnt_q <= FIRST_BIT; sr_q <= '0;
         zpend_q <= 1'b0; en_q <= 1'b0; req_n_q <= 1'b1; zero_q <= 1'b0;
         error_o <= 1'b0; done_o <= 1'b0;
      end
      else if (ce_i)
      begin
         // Set wins over the clear when both land together
         if (zero_req_i)
            zpend_q <= 1'b1;
         else if (st_q == H_ZERO)
            zpend_q <= 1'b0;
         tmr_q <= tmr_q + 16'h1;
         if (link.xfer_error && en_q && st_q != H_FAULT)
         begin
            // Drop enable; user restarts by cycling run_i
            st_q <= H_FAULT; en_q <= 1'b0; req_n_q <= 1'b1; zero_q <= 1'b0;
            error_o <= 1'b1;
         end
         else
            unique case (st_q)
               H_OFF:
                  if (run_i)
                  begin
                     st_q <= H_SETTLE; tmr_q <= '0; en_q <= 1'b1;
                     cnt_q <= FIRST_BIT; done_o <= 1'b0; error_o <= 1'b0;
                  end
               H_SETTLE:
                  if (tmr_q == SETTLE_LAST)
                  begin
                     tmr_q <= '0;
                     if (zpend_q)
                     begin
                        st_q <= H_ZERO; zero_q <= 1'b1;
                     end
                     else
                     begin
                        st_q <= H_REQ; req_n_q <= 1'b0;
                     end
                  end
               H_ZERO:
                  if (tmr_q == ZERO_LAST)
                  begin
                     st_q <= H_REQ; zero_q <= 1'b0; req_n_q <= 1'b0;
                  end
               H_REQ:
                  if (link.bit_ready)
                  begin
                     // Sample only while ready is high, then acknowledge
                     sr_q <= {link.bit_value, sr_q[15:1]};
                     cnt_q <= cnt_q + 7'h1;
                     st_q <= H_ACK; req_n_q <= 1'b1;
                  end
               H_ACK:
                  if (!link.bit_ready)
                  begin
                     if (cnt_q[3:0] == '0)
                        st_q <= H_PUSH;
                     else
                     begin
                        st_q <= H_REQ; req_n_q <= 1'b0;
                     end
                  end
               H_PUSH:
                  if (fifo_rdy)
                  begin
                     if (cnt_q == LAST_BIT + 7'h1)
                     begin
                        st_q <= H_DONE; en_q <= 1'b0; done_o <= 1'b1;
                     end
                     else
                     begin
                        st_q <= H_REQ; req_n_q <= 1'b0;
                     end
                  end
               H_DONE, H_FAULT:
                  if (!run_i)
                     st_q <= H_OFF;
            endcase
         if (st_q == H_FAULT && !run_i)
            error_o <= 1'b0;
      end
   end

   assign link.xfer_enable   = en_q;
   assign link.bit_request_n = req_n_q;
   assign link.coord_zero    = zero_q;

endmodule

//--- hw/abs_xfer_if.sv
// Discrete pins between the controller and the drive
`timescale 1ns/1ns
interface abs_xfer_if;
   logic xfer_enable;    // Controller: transfer mode on, high
   logic bit_request_n;  // Controller: low asks for a bit, high acknowledges
   logic coord_zero;     // Controller: rising edge zeroes the coordinates
   logic bit_ready;      // Drive: bit_value is valid, high
   logic bit_value;      // Drive: one frame bit
   logic xfer_error;     // Drive: acknowledge timed out, high

   modport dev (input xfer_enable, bit_request_n, coord_zero,
                output bit_ready, bit_value, xfer_error);
   modport host (output xfer_enable, bit_request_n, coord_zero,
                 input bit_ready, bit_value, xfer_error);
endinterface

//--- hw/abs_xfer_pkg.sv
// Shared constants for the absolute position bit handshake
package abs_xfer_pkg;

   // Clock period of ref_clk_i
   localparam int CLK_PERIOD_NS = 50;

   // Link times in ns (plain defaults, tune per installation)
   localparam int ENABLE_SETTLE_TIME_NS  = 10000;   // Enable to first request, least
   localparam int ZERO_HOLD_TIME_NS      = 5000;    // Zeroing input hold, least
   localparam int REQUEST_TO_READY_NS    = 1000;    // Request low to ready high
   localparam int ACK_TO_RELEASE_NS      = 1000;    // Request high to ready low
   localparam int ACK_TIMEOUT_NS         = 1000000; // Ready high to missing ack, longest

   // Cycle counts: least times round up, the longest time rounds down
   localparam int ENABLE_SETTLE_CYC =
      (ENABLE_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ZERO_HOLD_CYC =
      (ZERO_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REQUEST_TO_READY_CYC =
      (REQUEST_TO_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_TO_RELEASE_CYC =
      (ACK_TO_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_TIMEOUT_CYC_DFLT = ACK_TIMEOUT_NS / CLK_PERIOD_NS;

   // Frame layout
   localparam int FRAME_BITS = 80;
   localparam int WORD_BITS  = 16;
   localparam int IDX_W      = 7;
   localparam logic [IDX_W-1:0] LAST_BIT  = 7'h4f;
   localparam logic [IDX_W-1:0] FIRST_BIT = 7'h00;

   // Checksum addends
   localparam logic [15:0] CSUM_ADD0          = 16'ha700;
   localparam logic [15:0] CSUM_ADD1          = 16'h605a;
   localparam logic [15:0] CSUM_ADD2          = 16'h30a5;
   localparam logic [15:0] CSUM_FINAL_FORMULA = 16'h5a06;
   localparam logic [15:0] CSUM_FINAL_LIST    = 16'h50a6;
   localparam logic [15:0] CSUM_FINAL         = CSUM_FINAL_FORMULA;

   // Field limits and parameter codes
   localparam logic [31:0] PULSE_MAX        = 32'h0040_0000;
   localparam logic [15:0] COORD_INIT_VALUE = 16'h0001;

   // Receive buffer
   localparam int FIFO_DEPTH = 8;

endpackage

//--- tb/abs_position_bit_handshake_test.sv
// Bench: both link ends joined, plus a drive end steered by hand
`timescale 1ns/1ns
module abs_position_bit_handshake_test;
   import abs_xfer_pkg::*;
   logic        ref_clk_i, reset_n_i, ce, run, zreq, wrdy, pwr, dr, dv, de; // Stimulus
   logic [15:0] stat, revs, pdata, wdat; // Frame fields, parameter value, buffer word
   logic [31:0] puls;                    // Pulse count
   logic        wval, herr, hdone, rd1, zd1, ci1, fd1, rd2, zd2, ci2, fd2; // Observed
   int          err_count, cmp_count, init1, init2, rises, n; // Tallies
   logic [15:0] expq[$];                 // Words still due
   abs_xfer_if lnk ();                   // Design to design
   abs_xfer_if lnk2 ();                  // Bench acts as controller
   abs_xfer_dev #(.ACK_TIMEOUT_CYC(50)) u_abs_xfer_dev (.ref_clk_i, .reset_n_i, .ce_i(ce),
      .link(lnk), .status_word_i(stat), .revolutions_i(revs), .pulses_i(puls),
      .param_wr_i(pwr), .param_data_i(pdata), .dflt_ready_i(dr), .dflt_value_i(dv),
      .dflt_error_i(de), .req_dflt_o(rd1), .zero_dflt_o(zd1), .coord_init_o(ci1),
      .frame_done_o(fd1));
   abs_xfer_dev #(.ACK_TIMEOUT_CYC(50)) u_abs_xfer_dev_2 (.ref_clk_i, .reset_n_i, .ce_i(ce),
      .link(lnk2), .status_word_i(stat), .revolutions_i(revs), .pulses_i(puls),
      .param_wr_i(pwr), .param_data_i(pdata), .dflt_ready_i(dr), .dflt_value_i(dv),
      .dflt_error_i(de), .req_dflt_o(rd2), .zero_dflt_o(zd2), .coord_init_o(ci2),
      .frame_done_o(fd2));
   abs_xfer_host u_abs_xfer_host (.ref_clk_i, .reset_n_i, .ce_i(ce), .link(lnk), .run_i(run),
      .zero_req_i(zreq), .word_valid_o(wval), .word_data_o(wdat), .word_ready_i(wrdy),
      .error_o(herr), .done_o(hdone));
   abs_xfer_sva u_abs_xfer_sva (.ref_clk_i, .reset_n_i, .xfer_enable(lnk.xfer_enable),
      .bit_request_n(lnk.bit_request_n), .coord_zero(lnk.coord_zero),
      .bit_ready(lnk.bit_ready), .bit_value(lnk.bit_value), .xfer_error(lnk.xfer_error));
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk_i = 1'b0;
      forever #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;
   end
   // Event tallies; clearing pulses are one cycle, so count per edge
   always @(posedge ref_clk_i) init1 += (ci1 === 1'b1);
   always @(posedge ref_clk_i) init2 += (ci2 === 1'b1);
   always @(posedge lnk.bit_ready) rises++;
   // Hang guard, well beyond two frames and the hand-driven part
   initial
   begin
      #(CLK_PERIOD_NS * 40000);
      err_count++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tick(input int k);
      repeat (k) @(negedge ref_clk_i);
   endtask
   // Queue the five words one frame should deliver; pulses saturate
   task add_frame();
      logic [31:0] p;
      p = (puls > 32'h0040_0000) ? 32'h0040_0000 : puls;
      expq.push_back(stat);
      expq.push_back(revs);
      expq.push_back(p[15:0]);
      expq.push_back(p[31:16]);
      expq.push_back(((((((stat + 16'ha700) ^ revs) + 16'h605a) ^ p[15:0]) + 16'h30a5)
         ^ p[31:16]) + CSUM_FINAL);
   endtask
   task take_word(input logic [15:0] exp);
      for (n = 0; n < 9000 && wval !== 1'b1; n++) tick(1);
      chk({wval, wdat}, {1'b1, exp});
      @(posedge ref_clk_i) wrdy <= 1'b1;
      @(posedge ref_clk_i) wrdy <= 1'b0;
      tick(1);
   endtask
   task summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {ce, reset_n_i, run, zreq, wrdy, pwr, dr, dv, de} = 9'h100;
      {stat, revs, pdata, puls} = {16'h5a3d, 16'h7fff, 16'h0001, 32'h0040_0001};
      {lnk2.xfer_enable, lnk2.bit_request_n, lnk2.coord_zero} = 3'h2;
      repeat (5) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      // Disabled: pins keep default roles, zeroing edge ignored
      @(posedge ref_clk_i) {dr, dv, de, lnk2.bit_request_n, lnk2.coord_zero} <= 5'h1d;
      tick(3);
      chk({lnk2.bit_ready, lnk2.bit_value, lnk2.xfer_error, rd2, zd2}, 5'h1d);
      @(posedge ref_clk_i) {dr, de, lnk2.coord_zero, lnk2.bit_request_n, lnk2.xfer_enable} <= 5'h03;
      tick(ENABLE_SETTLE_CYC);
      chk({lnk2.bit_ready, lnk2.xfer_error, rd2, zd2}, 4'h2);
      chk(init2, 0);
      @(posedge ref_clk_i) lnk2.coord_zero <= 1'b1;
      tick(ZERO_HOLD_CYC);
      chk(init2, 1);
      // One bit requested, then never acknowledged
      @(posedge ref_clk_i) {lnk2.coord_zero, lnk2.bit_request_n} <= 2'h0;
      for (n = 0; n < 40 && lnk2.bit_ready !== 1'b1; n++) tick(1);
      chk(lnk2.bit_value, stat[0]);
      tick(60);
      chk({lnk2.xfer_error, lnk2.bit_ready}, 2'h2);
      @(posedge ref_clk_i) {lnk2.bit_request_n, lnk2.xfer_enable} <= 2'h2;
      tick(2);
      chk({lnk2.xfer_error, rd2}, 2'h1);
      @(posedge ref_clk_i) lnk2.xfer_enable <= 1'b1;
      tick(3);
      chk(lnk2.xfer_error, 1'b0);
      // Two parameter writes back to back, only the value one zeroes
      @(posedge ref_clk_i) pwr <= 1'b1;
      @(posedge ref_clk_i) pdata <= 16'h0002;
      @(posedge ref_clk_i) pwr <= 1'b0;
      tick(2);
      chk(init1, 1);
      // First frame left unread in the buffer
      rises = 0;
      add_frame();
      @(posedge ref_clk_i) run <= 1'b1;
      for (n = 0; n < 9000 && hdone !== 1'b1; n++) tick(1);
      chk({hdone, herr, fd1}, 3'h5);
      chk(rises, FRAME_BITS);
      @(posedge ref_clk_i) {run, zreq, stat, revs, puls} <= {2'h1, 64'h8001_8000_0012_3456};
      @(posedge ref_clk_i) {run, zreq} <= 2'h2;
      add_frame();
      // Buffer fills after three words; the fourth must hold the link
      for (n = 0; n < 9000 && rises < 144; n++) tick(1);
      tick(100);
      chk({rises[30:0], hdone}, {31'd144, 1'b0});
      chk(init1, 2);
      repeat (10) take_word(expq.pop_front());
      for (n = 0; n < 9000 && hdone !== 1'b1; n++) tick(1);
      chk({hdone, fd1, rises[29:0]}, {2'h2, 30'd160});
      summarize();
   end
endmodule

//--- tb/abs_xfer_sva.sv
// Checker on the pins between the controller end and the drive end
`timescale 1ns/1ns
module abs_xfer_sva
   import abs_xfer_pkg::*;
(
   input wire logic ref_clk_i,     // Clock
   input wire logic reset_n_i,     // Reset, low
   input wire logic xfer_enable,   // Transfer mode
   input wire logic bit_request_n, // Low asks, high acknowledges
   input wire logic coord_zero,    // Zeroing input
   input wire logic bit_ready,     // Bit valid
   input wire logic bit_value,     // Frame bit
   input wire logic xfer_error     // Ack timeout
);
   logic [15:0] en_cnt_q; // Cycles since enable, saturates
   logic [7:0]  bits_q;   // Bits served this session
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   ////////////////////////////////////////////////////////////////////////////
   // Counters restart whenever enable drops
   always_ff @(posedge ref_clk_i)
      if (!reset_n_i || !xfer_enable)
         en_cnt_q <= '0;
      else if (en_cnt_q != 16'hffff)
         en_cnt_q <= en_cnt_q + 16'h0001;
   always_ff @(posedge ref_clk_i)
      if (!reset_n_i || !xfer_enable)
         bits_q <= '0;
      else if ($rose(bit_ready))
         bits_q <= bits_q + 8'h01;
   ////////////////////////////////////////////////////////////////////////////
   sequence s_req;
      $fell(bit_request_n) && xfer_enable && !xfer_error;
   endsequence
   sequence s_ack;
      $rose(bit_request_n) && bit_ready;
   endsequence
   a_ready_after_req: assert property (s_req |-> !bit_ready [*8] ##[13:16] $rose(bit_ready))
      else $error("ready late or early after request");
   a_ready_release: assert property (s_ack |-> bit_ready [*8] ##[13:16] $fell(bit_ready))
      else $error("ready not released in time");
   a_ready_cause: assert property ($rose(bit_ready) && $past(xfer_enable) |->
      !bit_request_n && $past(bit_request_n, 19) == 1'b0) else $error("ready without request");
   a_value_held: assert property (xfer_enable && $past(xfer_enable) && bit_ready
      && $past(bit_ready) |-> $stable(bit_value)) else $error("bit changed while ready");
   a_no_error: assert property (xfer_enable && $past(xfer_enable) |-> !xfer_error)
      else $error("error with prompt acks");
   a_settle_wait: assert property (s_req |-> en_cnt_q >= ENABLE_SETTLE_CYC - 1)
      else $error("request before settle");
   a_zero_settle: assert property ($rose(coord_zero) |-> en_cnt_q >= ENABLE_SETTLE_CYC - 1)
      else $error("zeroing before settle");
   a_zero_hold: assert property ($fell(coord_zero) |->
      en_cnt_q >= ENABLE_SETTLE_CYC + ZERO_HOLD_CYC - 2) else $error("zeroing too short");
   a_frame_count: assert property ($fell(xfer_enable) |-> bits_q == FRAME_BITS)
      else $error("frame bit count wrong");
endmodule
